/* File: sffw_defs.vh */
`ifndef SFFW_DEFS_VH
`define SFFW_DEFS_VH

// feedback word layout
`define SFFW_WORD_W 32
`define SFFW_POS_W 25
`define SFFW_POS_LSB 0
`define SFFW_POS_MSB 24
`define SFFW_BIT_LIFE 31
`define SFFW_BIT_VALID 30
`define SFFW_BIT_CFGF 29
`define SFFW_BIT_GRPF 28
`define SFFW_BIT_AUX 27
`define SFFW_BIT_DN 26
`define SFFW_BIT_UP 25

// register map
`define SFFW_REG_FEEDBACK 4'h0
`define SFFW_ADDR_W 4

// reset values
`define SFFW_WORD_RST 32'h0000_0000
`define SFFW_POS_RST 25'h000_0000

// step count configuration
`define SFFW_STEPS_W 26
`define SFFW_TYPE_W 2
`define SFFW_TYPE_13 2'h0
`define SFFW_TYPE_21 2'h1
`define SFFW_TYPE_25 2'h2
`define SFFW_STEPS_MIN 26'h000_0002
`define SFFW_STEPS_MAX_13 26'h000_2000
`define SFFW_STEPS_MAX_21 26'h020_0000
`define SFFW_STEPS_MAX_25 26'h200_0000

// direction change: half of the 25-bit range decides wrap
`define SFFW_HALF_RANGE 25'h100_0000

`endif

/* File: sffw_dir_detect.v */
`timescale 1ns/10ps
`include "sffw_defs.vh"

module sffw_dir_detect (
    input wire clk_i,
    input wire sys_rst_i,
    input wire sample_i,
    input wire [`SFFW_POS_W-1:0] pos_i,
    output reg up_o,
    output reg down_o
);

reg [`SFFW_POS_W-1:0] last_pos;
reg have_last;
wire [`SFFW_POS_W-1:0] delta;

// modular difference: a short step backwards through zero is downward
assign delta = pos_i - last_pos;

always @(posedge clk_i) begin
    if (sys_rst_i) begin
        last_pos <= `SFFW_POS_RST;
        have_last <= 1'b0;
        up_o <= 1'b0;
        down_o <= 1'b0;
    end else if (sample_i) begin
        last_pos <= pos_i;
        have_last <= 1'b1;
        if (!have_last || delta == `SFFW_POS_RST) begin
            up_o <= 1'b0;
            down_o <= 1'b0;
        end else if (delta >= `SFFW_HALF_RANGE) begin
            up_o <= 1'b0;
            down_o <= 1'b1;
        end else begin
            up_o <= 1'b1;
            down_o <= 1'b0;
        end
    end
end

endmodule // sffw_dir_detect

/* File: sffw_feedback.v */
// Overview of operation
// - bit 31 is life toggle or zero
// - bit 30 operation_valid, only when valid
// - valid needs accepted config and running
// - config_fault reported in bit 29
// - fault when step count out of range
// - clear fault on good configuration
// - encoder_group_fault reported in bit 28
// - supply short, bad frame, parity set it
// - clears itself when all causes gone
// - aux input level in bit 27
// - moving_down_flag bit 26, wrap counts
// - moving_up_flag bit 25 on increase
// - position in bits 0 to 24
// - life toggle only in isochronous mode
// - toggle on each acquired sample
// - skipped samples leave toggle unchanged
`timescale 1ns/10ps
`include "sffw_defs.vh"

module sffw_feedback (
    input wire clk_i,
    input wire sys_rst_i,
    // configuration from host
    input wire cfg_load_i,
    input wire [`SFFW_TYPE_W-1:0] cfg_enc_type_i,
    input wire [`SFFW_STEPS_W-1:0] cfg_total_steps_i,
    input wire cfg_life_en_i,
    input wire iso_mode_i,
    input wire running_i,
    // acquisition from the frame receiver
    input wire sample_i,
    input wire [`SFFW_POS_W-1:0] pos_i,
    input wire frame_err_i,
    input wire parity_err_i,
    input wire supply_short_i,
    input wire aux_digital_input_i,
    // register read port
    input wire rd_i,
    input wire [`SFFW_ADDR_W-1:0] addr_i,
    output reg [`SFFW_WORD_W-1:0] rdata_o,
    output wire [`SFFW_WORD_W-1:0] fast_feedback_word_o
);

localparam ST_UNCONF = 2'b00;
localparam ST_BAD = 2'b01;
localparam ST_GOOD = 2'b10;

reg [1:0] state;
reg [1:0] next_state;
reg [`SFFW_WORD_W-1:0] fast_feedback_word;
reg life_toggle;
reg [`SFFW_POS_W-1:0] pos_hold;
wire config_fault;
wire operation_valid;
wire encoder_group_fault;
wire moving_up_flag;
wire moving_down_flag;
wire cfg_ok;
wire [`SFFW_WORD_W-1:0] next_word;

function steps_in_range;
    input [`SFFW_TYPE_W-1:0] enc_type;
    input [`SFFW_STEPS_W-1:0] steps;
    reg [`SFFW_STEPS_W-1:0] max_steps;
    begin
        case (enc_type)
            `SFFW_TYPE_13: max_steps = `SFFW_STEPS_MAX_13;
            `SFFW_TYPE_21: max_steps = `SFFW_STEPS_MAX_21;
            `SFFW_TYPE_25: max_steps = `SFFW_STEPS_MAX_25;
            default: max_steps = `SFFW_STEPS_MIN;
        endcase
        steps_in_range = (steps >= `SFFW_STEPS_MIN) && (steps <= max_steps);
    end
endfunction

assign cfg_ok = steps_in_range(cfg_enc_type_i, cfg_total_steps_i);

// config checker: each load decides good or bad afresh
always @* begin
    next_state = state;
    case (state)
        ST_UNCONF, ST_BAD, ST_GOOD: begin
            if (cfg_load_i) begin
                if (cfg_ok) begin
                    next_state = ST_GOOD;
                end else begin
                    next_state = ST_BAD;
                end
            end
        end
        default: next_state = ST_UNCONF;
    endcase
end

always @(posedge clk_i) begin
    if (sys_rst_i) begin
        state <= ST_UNCONF;
    end else begin
        state <= next_state;
    end
end

assign config_fault = (state == ST_BAD);
assign operation_valid = (state == ST_GOOD) && running_i;
// level-qualified, no acknowledge in fast mode
assign encoder_group_fault = supply_short_i | frame_err_i | parity_err_i;

sffw_dir_detect u_dir (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sample_i(sample_i),
    .pos_i(pos_i),
    .up_o(moving_up_flag),
    .down_o(moving_down_flag)
);

// direction flags land one edge after sample, so word refreshes a cycle later
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        pos_hold <= `SFFW_POS_RST;
        life_toggle <= 1'b0;
    end else begin
        if (sample_i) begin
            pos_hold <= pos_i;
        end
        if (!(cfg_life_en_i && iso_mode_i)) begin
            life_toggle <= 1'b0;
        end else if (sample_i) begin
            life_toggle <= ~life_toggle;
        end
    end
end

assign next_word = {
    life_toggle & cfg_life_en_i & iso_mode_i,
    operation_valid,
    config_fault,
    encoder_group_fault,
    aux_digital_input_i,
    moving_down_flag,
    moving_up_flag,
    pos_hold
};

// flags follow every cycle except while a fresh sample is in flight,
// so position and direction never come from different acquisitions
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        fast_feedback_word <= `SFFW_WORD_RST;
    end else if (!sample_i) begin
        fast_feedback_word <= next_word;
    end
end

assign fast_feedback_word_o = fast_feedback_word;

always @(posedge clk_i) begin
    if (sys_rst_i) begin
        rdata_o <= `SFFW_WORD_RST;
    end else if (rd_i) begin
        if (addr_i == `SFFW_REG_FEEDBACK) begin
            rdata_o <= fast_feedback_word;
        end else begin
            rdata_o <= `SFFW_WORD_RST;
        end
    end
end

endmodule // sffw_feedback

/* File: sffw_feedback_sva.sv */
`timescale 1ns/10ps
module sffw_feedback_sva (
    input wire clk_i,
    input wire sys_rst_i,
    input wire iso_mode_i,
    input wire running_i,
    input wire sample_i,
    input wire aux_digital_input_i,
    input wire rd_i,
    input wire [3:0] addr_i,
    input wire [31:0] rdata_o,
    input wire [31:0] fast_feedback_word_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire [31:0] w = fast_feedback_word_o;
    // sample cycles skipped: the word is frozen there
    a_life_off: assert property (!iso_mode_i && !sample_i |=> !w[31]) else $error("life bit");
    a_valid_run: assert property (!running_i && !sample_i |=> !w[30]) else $error("valid");
    a_aux_copy: assert property (!sample_i |=> w[27] == $past(aux_digital_input_i)) else $error("aux");
    a_dir_excl: assert property (!(w[26] && w[25])) else $error("dir");
    a_rd_word: assert property (rd_i && addr_i == 4'h0 |=> rdata_o == $past(w)) else $error("rdata");
    a_rd_unmap: assert property (rd_i && addr_i != 4'h0 |=> rdata_o == 32'h0) else $error("unmapped");
    a_rd_hold: assert property (!rd_i |=> $stable(rdata_o)) else $error("rdata moved");
    a_idle_flags: assert property ((!sample_i)[*3] |=> $stable(w[26:0])) else $error("flags");
endmodule // sffw_feedback_sva

/* File: sffw_host.sv */
`timescale 1ns/10ps
module sffw_host (
    input wire clk_i,
    input wire [31:0] rdata_i,
    output reg rd_o = 1'b0,
    output reg [3:0] addr_o = 4'h0
);
    task read(input [3:0] a, output [31:0] d);
        @(posedge clk_i) #2;
        {rd_o, addr_o} = {1'b1, a};
        @(posedge clk_i) #2;
        rd_o = 1'b0;
        d = rdata_i;
    endtask
endmodule // sffw_host

/* File: ssi_fast_feedback_word_bench.sv */
`timescale 1ns/10ps
module ssi_fast_feedback_word_bench;
    reg clk_i = 0, sys_rst_i = 1, cfg_load_i = 0, cfg_life_en_i = 0, iso_mode_i = 0, running_i = 1;
    reg sample_i = 0, frame_err_i = 0, parity_err_i = 0, supply_short_i = 0, aux_digital_input_i = 0;
    reg [1:0] cfg_enc_type_i = 0;
    reg [25:0] cfg_total_steps_i = 2;
    reg [24:0] pos_i = 0;
    reg [31:0] d;
    wire rd_i;
    wire [3:0] addr_i;
    wire [31:0] rdata_o, fast_feedback_word_o;
    integer n_errors = 0, compares = 0, i;
    sffw_feedback u_sffw_feedback (.*);
    sffw_host u_sffw_host (.clk_i, .rdata_i(rdata_o), .rd_o(rd_i), .addr_o(addr_i));
    task check(input [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h", $time, got);
        end
    endtask
    task ck(input [31:0] m, e);
        u_sffw_host.read(4'h0, d);
        check(d & m, e);
        check(fast_feedback_word_o & m, e);
    endtask
    // gap cycles after each sample keep the word from freezing
    task smp(input [24:0] p);
        {sample_i, pos_i} = {1'b1, p};
        repeat (4) @(posedge clk_i) #2 sample_i = 0;
    endtask
    task cfg(input [27:0] v);
        {cfg_enc_type_i, cfg_total_steps_i, cfg_load_i} = {v, 1'b1};
        @(posedge clk_i) #2 cfg_load_i = 0;
    endtask
    task end_sim;
        $display("%0d compares %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        #50000;
        n_errors++;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        #2 sys_rst_i = 0;
        cfg(28'h000_2001);
        ck(32'h6000_0000, 32'h2000_0000);
        cfg(28'h000_2000);
        ck(32'h6000_0000, 32'h4000_0000);
        running_i = 0;
        ck(32'h4000_0000, 32'h0);
        running_i = 1;
        $display("config test done");
        smp(25'h10);
        smp(25'h20);
        ck(32'h07FF_FFFF, 32'h0200_0020);
        smp(25'h1FF_FFFF);
        ck(32'h0600_0000, 32'h0400_0000);
        {iso_mode_i, cfg_life_en_i} = 2'h3;
        smp(25'h3);
        ck(32'h8000_0000, 32'h8000_0000);
        ck(32'h8000_0000, 32'h8000_0000);
        iso_mode_i = 0;
        smp(25'h3);
        ck(32'h8000_0000, 32'h0);
        $display("sample test done");
        for (i = 0; i < 3; i++) begin
            {frame_err_i, parity_err_i, supply_short_i} = 3'h4 >> i;
            ck(32'h1000_0000, 32'h1000_0000);
            {frame_err_i, parity_err_i, supply_short_i} = 3'h0;
            ck(32'h1000_0000, 32'h0);
        end
        aux_digital_input_i = 1;
        ck(32'h0800_0000, 32'h0800_0000);
        u_sffw_host.read(4'h4, d);
        check(d, 32'h0);
        $display("fault test done");
        sys_rst_i = 1;
        @(posedge clk_i) #2;
        check(fast_feedback_word_o, 32'h0);
        check(rdata_o, 32'h0);
        sys_rst_i = 0;
        $display("reset test done");
        end_sim;
    end
endmodule // ssi_fast_feedback_word_bench
bind sffw_feedback sffw_feedback_sva u_sva (.*);
